// ---- include/bcc_pkg.sv ----
// Constants, field layout and sequencer states of the bridge control
// configuration block.
// Assumes a 32-bit APB with byte addresses in an 8-bit window.
package bcc_pkg;
  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int CFG_W  = 8;
  localparam int EVT_W  = 3;
  localparam int ST_W   = 4;
  localparam int AUD_W  = 32;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CFG_OFS     = 8'h54;
  localparam logic [ADDR_W-1:0] IRQ_STS_OFS = 8'h60;
  localparam logic [ADDR_W-1:0] IRQ_EN_OFS  = 8'h64;
  localparam logic [ADDR_W-1:0] IRQ_CLR_OFS = 8'h68;
  localparam logic [ADDR_W-1:0] STATE_OFS   = 8'h6C;

  // ------------------------------------------------------------
  // Configuration fields
  // ------------------------------------------------------------
  localparam int CFG_EXT_BIT    = 7;
  localparam int CFG_RXIRQ_BIT  = 6;
  localparam int CFG_EDBYP_BIT  = 5;
  localparam int CFG_INHIB_BIT  = 4;
  localparam int CFG_TDM_BIT    = 2;
  localparam int CFG_SRC_BIT    = 1;
  localparam int CFG_AUX_BIT    = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
  localparam logic [CFG_W-1:0] CFG_WMASK = 8'hF7;

  // ------------------------------------------------------------
  // Event and state bits
  // ------------------------------------------------------------
  localparam int EVT_RXIRQ = 0;
  localparam int EVT_EDID  = 1;
  localparam int EVT_INIT  = 2;
  localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
  localparam int ST_RXIRQ  = 0;
  localparam int ST_EDID   = 1;
  localparam int ST_INIT   = 2;
  localparam int ST_BUSY   = 3;

  typedef enum logic [2:0] {
    SEQ_STRAP,
    SEQ_EDID_REQ,
    SEQ_EDID_WAIT,
    SEQ_IDLE,
    SEQ_INIT_REQ,
    SEQ_INIT_WAIT
  } bcc_seq_t;
endpackage

// ---- design/bcc_strap_capture.sv ----
// Strap capture: one load pulse in the first cycle after reset release.
// Assumes the strap pins are stable and synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module bcc_strap_capture
  import bcc_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      strapSelectOne,
  input  wire logic                      strapSelectZero,
  output logic                           strapLoad,
  output logic [bcc_pkg::CFG_W-1:0]      strapBits
);
  logic armed;

  // Reset may only load constants, so the pins are caught afterwards
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      armed <= 1'b1;
    end else begin
      armed <= 1'b0;
    end
  end

  assign strapLoad = armed & ~sys_rst;

  always_comb begin
    strapBits                = '0;
    strapBits[CFG_EXT_BIT]   = strapSelectOne;
    strapBits[CFG_EDBYP_BIT] = strapSelectOne;
    strapBits[CFG_AUX_BIT]   = strapSelectZero;
  end
endmodule
`default_nettype wire

// ---- design/bcc_sticky_status.sv ----
// Sticky event status with enable mask and one level interrupt.
// Assumes events and clears are one-cycle pulses on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module bcc_sticky_status
  import bcc_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  input  wire logic [bcc_pkg::EVT_W-1:0] evtPulse,
  input  wire logic                      clrWrite,
  input  wire logic [bcc_pkg::EVT_W-1:0] clrMask,
  input  wire logic [bcc_pkg::EVT_W-1:0] evtEnable,
  output logic [bcc_pkg::EVT_W-1:0]      evtStatus,
  output logic                           irq
);
  genvar i;
  generate
    for (i = 0; i < EVT_W; i++) begin : g_bit
      // A new event beats a clear landing in the same cycle
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          evtStatus[i] <= 1'b0;
        end else if (evtPulse[i]) begin
          evtStatus[i] <= 1'b1;
        end else if (clrWrite && clrMask[i]) begin
          evtStatus[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(evtStatus & evtEnable);
endmodule
`default_nettype wire

// ---- design/bcc_bridge_control_config.sv ----
// Bridge control configuration register with its APB slave, the
// start-up sequencer for remote EDID load and receiver setup, the
// receiver interrupt forwarding and the audio source routing.
// Assumes a zero-wait APB master, synchronous strap pins and
// receiver/EDID engines that answer start pulses with done pulses.
//
// Contract
// - see the external-control bit; when set, internal bridge control and receiver setup stop.
// - with the receiver interrupt enable set, receiver interrupts drive the active-low pin.
// - with the EDID bypass bit clear, the block starts the remote EDID search and copy; the code checks the bit only once, right after the strap load.
// - with the EDID bypass bit set, no remote EDID load is started; it powers up from strap one.
// - receiver setup runs automatically unless the setup inhibit bit is written to one.
// - the TDM bit puts receiver audio handling in time-division multiplexed form.
// - the source bit picks receiver audio (0) or local serial audio (1) for the link.
// - the auxiliary bit enables an extra two-channel audio stream beside main audio.
// - the auxiliary enable powers up from the strap zero pin.
`timescale 1ns/1ps
`default_nettype none
module bcc_bridge_control_config
(
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,

  input  wire logic [bcc_pkg::ADDR_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [bcc_pkg::DATA_W-1:0] pwdata,
  input  wire logic [bcc_pkg::STRB_W-1:0] pstrb,
  output logic [bcc_pkg::DATA_W-1:0]      prdata,
  output logic                            pready,
  output logic                            pslverr,

  input  wire logic                       strapSelectOne,
  input  wire logic                       strapSelectZero,

  input  wire logic                       rxIrqIn,
  output logic                            interruptOutN,
  output logic                            irq,

  output logic                            internalCtlEnable,
  output logic                            edidLoadStart,
  input  wire logic                       edidLoadDone,
  output logic                            rxInitStart,
  input  wire logic                       rxInitDone,

  output logic                            tdmAudioMode,
  input  wire logic [bcc_pkg::AUD_W-1:0]  rxAudioData,
  input  wire logic                       rxAudioValid,
  input  wire logic [bcc_pkg::AUD_W-1:0]  localAudioData,
  input  wire logic                       localAudioValid,
  input  wire logic [bcc_pkg::AUD_W-1:0]  auxAudioData,
  input  wire logic                       auxAudioValid,
  output logic [bcc_pkg::AUD_W-1:0]       linkAudioData,
  output logic                            linkAudioValid,
  output logic [bcc_pkg::AUD_W-1:0]       linkAuxData,
  output logic                            linkAuxValid
);
  import bcc_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [CFG_W-1:0]  bridgeConfig;
  logic [EVT_W-1:0]  irqEnable;
  logic [EVT_W-1:0]  irqStatus;
  logic [EVT_W-1:0]  evtPulse;
  logic [ST_W-1:0]   bridgeState;
  logic [CFG_W-1:0]  strapBits;
  logic              strapLoad;
  logic              edidLoaded;
  logic              initDone;
  logic              rxIrqPrev;
  logic              pinAssert;
  bcc_seq_t          seqState;
  bcc_seq_t          next_seqState;

  wire               outsideControllerSelect;
  wire               receiverIrqEnable;
  wire               farEdidLoadBypass;
  wire               selfSetupInhibit;
  wire               tdmEnable;
  wire               audioSourceLocal;
  wire               auxAudioEnable;

  wire               apbSetup;
  wire               apbAccess;
  wire               hitCfg;
  wire               hitSts;
  wire               hitEn;
  wire               hitClr;
  wire               hitState;
  wire               addrHit;
  wire               wrLane0;
  wire               wrCfg;
  wire               wrEn;
  wire               wrClr;
  wire [DATA_W-1:0]  readValue;
  wire               initAllowed;
  wire               initAbort;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic regHit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs
  );
    regHit = (addr == ofs);
  endfunction

  assign apbSetup  = psel & ~penable;
  assign apbAccess = psel & penable;
  assign hitCfg    = regHit(paddr, CFG_OFS);
  assign hitSts    = regHit(paddr, IRQ_STS_OFS);
  assign hitEn     = regHit(paddr, IRQ_EN_OFS);
  assign hitClr    = regHit(paddr, IRQ_CLR_OFS);
  assign hitState  = regHit(paddr, STATE_OFS);
  assign addrHit   = hitCfg | hitSts | hitEn | hitClr | hitState;

  // Every register lives in byte lane 0; other lanes are ignored
  assign wrLane0   = apbAccess & pwrite & pstrb[0];
  assign wrCfg     = wrLane0 & hitCfg;
  assign wrEn      = wrLane0 & hitEn;
  assign wrClr     = wrLane0 & hitClr;

  // ------------------------------------------------------------
  // APB answer
  // ------------------------------------------------------------
  // No wait states: data is fetched in the setup cycle, so the
  // access cycle completes at once with registered read data
  assign pready  = 1'b1;
  assign pslverr = apbAccess & ~addrHit;

  assign readValue =
      hitCfg   ? {{(DATA_W-CFG_W){1'b0}}, bridgeConfig} :
      hitSts   ? {{(DATA_W-EVT_W){1'b0}}, irqStatus}    :
      hitEn    ? {{(DATA_W-EVT_W){1'b0}}, irqEnable}    :
      hitState ? {{(DATA_W-ST_W){1'b0}},  bridgeState}  :
      {DATA_W{1'b0}};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (apbSetup && !pwrite) begin
      prdata <= readValue;
    end
  end

  // ------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------
  bcc_strap_capture u_strap (
    .sys_clk         (sys_clk),
    .sys_rst         (sys_rst),
    .strapSelectOne  (strapSelectOne),
    .strapSelectZero (strapSelectZero),
    .strapLoad       (strapLoad),
    .strapBits       (strapBits)
  );

  // ------------------------------------------------------------
  // Configuration register
  // ------------------------------------------------------------
  // Strapped fields are loaded once, in the first cycle after
  // reset; bit 3 is masked on every write so it always reads zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bridgeConfig <= CFG_RESET;
    end else if (strapLoad) begin
      bridgeConfig <= strapBits;
    end else if (wrCfg) begin
      bridgeConfig <= pwdata[CFG_W-1:0] & CFG_WMASK;
    end
  end

  assign outsideControllerSelect = bridgeConfig[CFG_EXT_BIT];
  assign receiverIrqEnable       = bridgeConfig[CFG_RXIRQ_BIT];
  assign farEdidLoadBypass       = bridgeConfig[CFG_EDBYP_BIT];
  assign selfSetupInhibit        = bridgeConfig[CFG_INHIB_BIT];
  assign tdmEnable               = bridgeConfig[CFG_TDM_BIT];
  assign audioSourceLocal        = bridgeConfig[CFG_SRC_BIT];
  assign auxAudioEnable          = bridgeConfig[CFG_AUX_BIT];

  // The outside controller owns the receiver while this is low
  assign internalCtlEnable = ~outsideControllerSelect;
  assign tdmAudioMode      = tdmEnable;

  // ------------------------------------------------------------
  // Start-up sequencer
  // ------------------------------------------------------------
  // Until setup has completed once, it is retried from idle whenever software lifts the inhibit
  // or hands control back, so a late change is not lost
  assign initAllowed = ~outsideControllerSelect
                     & ~selfSetupInhibit;
  assign initAbort   = ~initAllowed;

  always_comb begin
    next_seqState = seqState;
    unique case (seqState)
      SEQ_STRAP: begin
        if (!strapLoad) begin
          if (farEdidLoadBypass) begin
            next_seqState = SEQ_IDLE;
          end else begin
            next_seqState = SEQ_EDID_REQ;
          end
        end
      end
      SEQ_EDID_REQ: begin
        next_seqState = SEQ_EDID_WAIT;
      end
      SEQ_EDID_WAIT: begin
        if (edidLoadDone) begin
          next_seqState = SEQ_IDLE;
        end
      end
      SEQ_IDLE: begin
        if (!initDone && initAllowed) begin
          next_seqState = SEQ_INIT_REQ;
        end
      end
      SEQ_INIT_REQ: begin
        next_seqState = SEQ_INIT_WAIT;
      end
      SEQ_INIT_WAIT: begin
        if (rxInitDone || initAbort) begin
          next_seqState = SEQ_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seqState <= SEQ_STRAP;
    end else begin
      seqState <= next_seqState;
    end
  end

  // Start requests are single-cycle pulses
  assign edidLoadStart = (seqState == SEQ_EDID_REQ);
  assign rxInitStart   = (seqState == SEQ_INIT_REQ)
                       & initAllowed;

  // ------------------------------------------------------------
  // Progress flags and events
  // ------------------------------------------------------------
  assign evtPulse[EVT_EDID]  = (seqState == SEQ_EDID_WAIT) & edidLoadDone;
  assign evtPulse[EVT_INIT]  = (seqState == SEQ_INIT_WAIT) & rxInitDone
                             & initAllowed;
  assign evtPulse[EVT_RXIRQ] = rxIrqIn & ~rxIrqPrev;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      edidLoaded <= 1'b0;
      initDone   <= 1'b0;
      rxIrqPrev  <= 1'b0;
    end else begin
      rxIrqPrev <= rxIrqIn;
      if (evtPulse[EVT_EDID]) begin
        edidLoaded <= 1'b1;
      end
      if (evtPulse[EVT_INIT]) begin
        initDone <= 1'b1;
      end
    end
  end

  // Software reads this to tell a receiver interrupt from others
  assign bridgeState[ST_RXIRQ] = rxIrqPrev;
  assign bridgeState[ST_EDID]  = edidLoaded;
  assign bridgeState[ST_INIT]  = initDone;
  assign bridgeState[ST_BUSY]  = (seqState != SEQ_IDLE);

  // ------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqEnable <= EVT_RESET;
    end else if (wrEn) begin
      irqEnable <= pwdata[EVT_W-1:0];
    end
  end

  bcc_sticky_status u_status (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .evtPulse  (evtPulse),
    .clrWrite  (wrClr),
    .clrMask   (pwdata[EVT_W-1:0]),
    .evtEnable (irqEnable),
    .evtStatus (irqStatus),
    .irq       (irq)
  );

  // ------------------------------------------------------------
  // Interrupt pin
  // ------------------------------------------------------------
  // The pin follows the receiver level one cycle late; masked
  // receiver interrupts still show in the state register
  assign pinAssert = rxIrqIn & receiverIrqEnable;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      interruptOutN <= 1'b1;
    end else begin
      interruptOutN <= ~pinAssert;
    end
  end

  // ------------------------------------------------------------
  // Audio routing
  // ------------------------------------------------------------
  // Switching source mid-stream may drop or split one sample;
  // software should change it only while audio is idle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      linkAudioData  <= '0;
      linkAudioValid <= 1'b0;
    end else if (audioSourceLocal) begin
      linkAudioValid <= localAudioValid;
      if (localAudioValid) begin
        linkAudioData <= localAudioData;
      end
    end else begin
      linkAudioValid <= rxAudioValid;
      if (rxAudioValid) begin
        linkAudioData <= rxAudioData;
      end
    end
  end

  // Aux stream is independent of the main source selection
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      linkAuxData  <= '0;
      linkAuxValid <= 1'b0;
    end else begin
      linkAuxValid <= auxAudioEnable & auxAudioValid;
      if (auxAudioEnable && auxAudioValid) begin
        linkAuxData <= auxAudioData;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/bcc_cfg_properties.sv ----
// Checker for the bridge control configuration block.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module bcc_cfg_properties (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxIrqIn,
  input wire logic interruptOutN,
  input wire logic internalCtlEnable,
  input wire logic edidLoadStart,
  input wire logic rxInitStart,
  input wire logic rxAudioValid,
  input wire logic localAudioValid,
  input wire logic auxAudioValid,
  input wire logic linkAudioValid,
  input wire logic linkAuxValid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  ready_in_access_a:
    assert property (psel && penable |-> pready) else $error("pready low in access");
  error_in_access_a:
    assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  pin_from_rx_a:
    assert property (!interruptOutN |-> $past(rxIrqIn)) else $error("pin low without receiver irq");
  pin_idle_a:
    assert property (!$past(rxIrqIn) |-> interruptOutN) else $error("pin low with receiver idle");
  init_needs_int_a:
    assert property (rxInitStart |-> internalCtlEnable) else $error("setup under outside control");
  init_pulse_a:
    assert property (rxInitStart |=> !rxInitStart) else $error("setup start too long");
  edid_after_rst_a:
    assert property (edidLoadStart |-> $past(sys_rst, 2) || $past(sys_rst, 3)) else $error("late EDID start");
  edid_pulse_a:
    assert property (edidLoadStart |=> !edidLoadStart) else $error("EDID start too long");
  aux_gate_a:
    assert property (linkAuxValid |-> $past(auxAudioValid)) else $error("aux valid without input");
  main_valid_a:
    assert property (linkAudioValid |-> $past(rxAudioValid || localAudioValid)) else $error("main valid alone");

  cover property (edidLoadStart);
  cover property (rxInitStart);
  cover property (!interruptOutN);
endmodule
bind bcc_bridge_control_config bcc_cfg_properties chk_u (
  .sys_clk, .sys_rst, .psel, .penable, .pready, .pslverr, .rxIrqIn, .interruptOutN,
  .internalCtlEnable, .edidLoadStart, .rxInitStart, .rxAudioValid, .localAudioValid,
  .auxAudioValid, .linkAudioValid, .linkAuxValid
);
`default_nettype wire

// ---- sim/bcc_engine_model.sv ----
// Model of the EDID load and receiver setup engines beside the block.
// Assumes one-cycle start pulses; answers lat+1 cycles later (lat >= 1).
`timescale 1ns/1ps
`default_nettype none
module bcc_engine_model (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] lat,
  input  wire logic       edidLoadStart,
  input  wire logic       rxInitStart,
  output logic            edidLoadDone,
  output logic            rxInitDone
);
  logic [3:0] edidCnt;
  logic [3:0] initCnt;
  // Done is a one-cycle pulse; the sequencer ignores it outside its wait
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      edidCnt <= 4'h0;
      initCnt <= 4'h0;
      edidLoadDone <= 1'b0;
      rxInitDone <= 1'b0;
    end else begin
      edidLoadDone <= (edidCnt == 4'h1);
      rxInitDone <= (initCnt == 4'h1);
      edidCnt <= edidLoadStart ? lat : (edidCnt != 4'h0 ? edidCnt - 4'h1 : 4'h0);
      initCnt <= rxInitStart ? lat : (initCnt != 4'h0 ? initCnt - 4'h1 : 4'h0);
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench: APB register accesses plus pin and audio checks.
// Assumes the engine model answers the sequencer's start pulses.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bcc_pkg::*;
  logic              sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, q;
  logic [STRB_W-1:0] pstrb;
  logic              strapSelectOne, strapSelectZero, rxIrqIn, interruptOutN, irq, e;
  logic              internalCtlEnable, edidLoadStart, edidLoadDone, rxInitStart, rxInitDone;
  logic              tdmAudioMode, rxAudioValid, localAudioValid, auxAudioValid;
  logic              linkAudioValid, linkAuxValid;
  logic [AUD_W-1:0]  rxAudioData, localAudioData, auxAudioData, linkAudioData, linkAuxData;
  logic [3:0]        lat;
  int                fail_count, n_checks;

  bcc_bridge_control_config dut_u (
    .sys_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .strapSelectOne, .strapSelectZero, .rxIrqIn, .interruptOutN, .irq,
    .internalCtlEnable, .edidLoadStart, .edidLoadDone, .rxInitStart, .rxInitDone,
    .tdmAudioMode, .rxAudioData, .rxAudioValid, .localAudioData, .localAudioValid,
    .auxAudioData, .auxAudioValid, .linkAudioData, .linkAudioValid, .linkAuxData, .linkAuxValid
  );
  bcc_engine_model eng_u (
    .sys_clk, .sys_rst, .lat, .edidLoadStart, .rxInitStart, .edidLoadDone, .rxInitDone
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until pready is seen high; q and e take the answer there
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // Polls a register until the masked bits match or 30 reads pass, then compares once
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((q & m) !== exp && n < 30);
    chk(q & m, exp);
  endtask

  task automatic rst_run(input logic s1, input logic s0, input logic [3:0] l);
    @(posedge sys_clk);
    strapSelectOne <= s1;
    strapSelectZero <= s0;
    lat <= l;
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #(100 * 5000);
    fail_count++;
    final_report();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, rxIrqIn} = '0;
    {rxAudioValid, localAudioValid, auxAudioValid} = '0;
    {rxAudioData, localAudioData, auxAudioData} = '0;
    pstrb = 4'hF;
    sys_rst = 1'b1;
    fail_count = 0;
    n_checks = 0;
    rst_run(1'b0, 1'b1, 4'h1);
    rd(CFG_OFS, 32'h01);
    poll(STATE_OFS, 32'h0F, 32'h06);
    rd(IRQ_STS_OFS, 32'h06);
    chk(internalCtlEnable, 1'b1);
    apb(1'b1, IRQ_CLR_OFS, 32'h07);
    rd(IRQ_STS_OFS, 32'h00);
    $display("test strap start-up done");

    apb(1'b1, CFG_OFS, 32'hFF);
    rd(CFG_OFS, 32'hF7);
    pstrb <= 4'h0;
    apb(1'b1, CFG_OFS, 32'h00);
    pstrb <= 4'hF;
    rd(CFG_OFS, 32'hF7);
    chk(tdmAudioMode, 1'b1);
    chk(internalCtlEnable, 1'b0);
    rd(8'h70, 32'h0);
    chk(e, 1'b1);
    $display("test register access done");

    apb(1'b1, IRQ_EN_OFS, 32'h01);
    rxIrqIn <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(interruptOutN, 1'b0);
    chk(irq, 1'b1);
    apb(1'b1, IRQ_CLR_OFS, 32'h01);
    @(negedge sys_clk);
    chk(irq, 1'b0);
    rxIrqIn <= 1'b0;
    apb(1'b1, CFG_OFS, 32'h00);
    rxIrqIn <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(interruptOutN, 1'b1);
    chk(irq, 1'b1);
    apb(1'b1, IRQ_EN_OFS, 32'h00);
    @(negedge sys_clk);
    chk(irq, 1'b0);
    rd(STATE_OFS, 32'h07);
    rd(IRQ_STS_OFS, 32'h01);
    apb(1'b1, IRQ_CLR_OFS, 32'h01);
    rxIrqIn <= 1'b0;
    $display("test interrupt done");

    {rxAudioValid, localAudioValid, auxAudioValid} <= 3'h7;
    rxAudioData <= 32'hA1A1_0001;
    localAudioData <= 32'hB2B2_0002;
    auxAudioData <= 32'hC3C3_0003;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(linkAudioData, 32'hA1A1_0001);
    chk(linkAudioValid, 1'b1);
    chk(linkAuxValid, 1'b0);
    apb(1'b1, CFG_OFS, 32'h03);
    // The new source reaches the link outputs one edge after the write
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(tdmAudioMode, 1'b0);
    chk(linkAudioValid, 1'b1);
    chk(linkAudioData, 32'hB2B2_0002);
    chk(linkAuxData, 32'hC3C3_0003);
    chk(linkAuxValid, 1'b1);
    $display("test audio routing done");

    rst_run(1'b1, 1'b0, 4'h6);
    rd(CFG_OFS, 32'hA0);
    rd(STATE_OFS, 32'h00);
    apb(1'b1, CFG_OFS, 32'h30);
    rd(STATE_OFS, 32'h00);
    apb(1'b1, CFG_OFS, 32'h20);
    poll(STATE_OFS, 32'h06, 32'h04);
    rd(IRQ_STS_OFS, 32'h04);
    $display("test strapped bypass done");
    final_report();
  end
endmodule
`default_nettype wire
